// ===== verilog/wdt_pkg.sv
`default_nettype none
package wdt_pkg;
  // Register byte offsets
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 4'h0;
  localparam logic [ADDR_W-1:0] COUNT_OFF = 4'h4;
  localparam logic [ADDR_W-1:0] ISTAT_OFF = 4'h8;
  localparam logic [ADDR_W-1:0] IMASK_OFF = 4'hc;
  // Control register bit positions
  localparam int CWE_GUARD_BIT = 7;
  localparam int CWE_BIT = 6;
  localparam int RWE_GUARD_BIT = 5;
  localparam int RWE_BIT = 4;
  localparam int RUN_GUARD_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int FLAG_GUARD_BIT = 1;
  localparam int FLAG_BIT = 0;
  // Interrupt status bit for counter overflow
  localparam int OVF_IRQ_BIT = 0;
  localparam int IRQ_W = 1;
  // Reset values and guard bit read value
  localparam logic CTRL_BIT_RESET = 1'b0;
  localparam logic GUARD_READ = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 1'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Default counter width and tick divider
  localparam int CNT_W_DEF = 8;
  localparam int TICK_DIV_DEF = 256;

  // Stored control bits
  typedef struct packed {
    logic cwe;
    logic rwe;
    logic run;
    logic flag;
  } ctrl_s;
endpackage
`default_nettype wire

// ===== verilog/wdt_guarded_control.sv
`default_nettype none
module wdt_guarded_control
  import wdt_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF,
  parameter int TICK_DIV = TICK_DIV_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic wdt_reset
);

  localparam int DIV_W = $clog2(TICK_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  logic aw_full_r, w_full_r, bvalid_r, awready_r, wready_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic arready_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  ctrl_s ctrl_r;
  logic [CNT_W-1:0] count_r;
  logic [DIV_W-1:0] div_r;
  logic tick;
  logic overflow;
  logic wdt_reset_r;
  logic [IRQ_W-1:0] istat_r, imask_r;
  logic irq_r;
  logic aw_take, w_take, wr_fire, ar_take;
  logic aw_full_nxt, w_full_nxt;
  logic ctrl_wr, count_wr, istat_wr, imask_wr, wr_mapped;
  logic [7:0] wd;
  logic [7:0] ctrl_view;
  logic [31:0] rd_word;
  logic rd_mapped;

  // Write channel handshakes; address and data taken in either order
  assign aw_take = s_axi_awvalid & awready_r;
  assign w_take = s_axi_wvalid & wready_r;
  assign wr_fire = aw_full_r & w_full_r & ~bvalid_r;
  assign aw_full_nxt = (aw_full_r | aw_take) & ~wr_fire;
  assign w_full_nxt = (w_full_r | w_take) & ~wr_fire;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= ~aw_full_nxt;
      wready_r <= ~w_full_nxt;
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  // Write decode; only the low byte lane carries register bits
  assign wd = wdata_r[7:0];
  assign ctrl_wr = wr_fire & (awaddr_r == CTRL_OFF) & wstrb_r[0];
  assign count_wr = wr_fire & (awaddr_r == COUNT_OFF) & wstrb_r[0];
  assign istat_wr = wr_fire & (awaddr_r == ISTAT_OFF) & wstrb_r[0];
  assign imask_wr = wr_fire & (awaddr_r == IMASK_OFF) & wstrb_r[0];
  assign wr_mapped = (awaddr_r == CTRL_OFF) | (awaddr_r == COUNT_OFF) |
                     (awaddr_r == ISTAT_OFF) | (awaddr_r == IMASK_OFF);

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read path: one word per request, answered next cycle
  assign ar_take = s_axi_arvalid & arready_r;
  assign ctrl_view = {GUARD_READ, ctrl_r.cwe, GUARD_READ, ctrl_r.rwe,
                      GUARD_READ, ctrl_r.run, GUARD_READ, ctrl_r.flag};

  always_comb begin
    rd_word = '0;
    rd_mapped = 1'b1;
    unique case (s_axi_araddr)
      CTRL_OFF: rd_word[7:0] = ctrl_view;
      COUNT_OFF: rd_word[CNT_W-1:0] = count_r;
      ISTAT_OFF: rd_word[IRQ_W-1:0] = istat_r;
      IMASK_OFF: rd_word[IRQ_W-1:0] = imask_r;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= ~(ar_take | (rvalid_r & ~s_axi_rready));
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Counter write enable and register write enable, own guards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r.cwe <= CTRL_BIT_RESET;
      ctrl_r.rwe <= CTRL_BIT_RESET;
    end else if (ctrl_wr) begin
      if (!wd[CWE_GUARD_BIT]) begin
        ctrl_r.cwe <= wd[CWE_BIT];
      end
      if (!wd[RWE_GUARD_BIT]) begin
        ctrl_r.rwe <= wd[RWE_BIT];
      end
    end
  end

  // Run enable: guard 0 and register enable already set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r.run <= CTRL_BIT_RESET;
    end else if (ctrl_wr && ctrl_r.rwe && !wd[RUN_GUARD_BIT]) begin
      ctrl_r.run <= wd[RUN_BIT];
    end
  end

  // Overflow flag; overflow wins over a clearing write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r.flag <= CTRL_BIT_RESET;
    end else if (overflow) begin
      ctrl_r.flag <= 1'b1;
    end else if (ctrl_wr && ctrl_r.rwe && !wd[FLAG_GUARD_BIT]) begin
      ctrl_r.flag <= wd[FLAG_BIT];
    end
  end

  // Tick divider, runs only while counting
  assign tick = ctrl_r.run & (div_r == DIV_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_r.run || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DIV_W'(1);
    end
  end

  // Watchdog counter; software load beats the tick
  // A refused write (cwe low) must not swallow the overflow
  assign overflow = tick & ~(count_wr & ctrl_r.cwe) & (count_r == CNT_MAX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
    end else if (count_wr && ctrl_r.cwe) begin
      count_r <= wd[CNT_W-1:0];
    end else if (tick) begin
      count_r <= count_r + CNT_W'(1);
    end
  end

  // Internal reset pulse on overflow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_reset_r <= 1'b0;
    end else begin
      wdt_reset_r <= overflow;
    end
  end

  // Sticky status, write one to clear, set wins; mask and level irq
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_r <= IRQ_RESET;
      imask_r <= IRQ_RESET;
      irq_r <= 1'b0;
    end else begin
      istat_r[OVF_IRQ_BIT] <= overflow |
        (istat_r[OVF_IRQ_BIT] & ~(istat_wr & wd[OVF_IRQ_BIT]));
      if (imask_wr) begin
        imask_r <= wd[IRQ_W-1:0];
      end
      irq_r <= |(istat_r & imask_r);
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign irq = irq_r;
  assign wdt_reset = wdt_reset_r;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_guarded_ctrl_wr(int g);
    ctrl_wr && wd[g];
  endsequence

  sequence s_overflow_seen;
    ctrl_r.run && tick && !(count_wr && ctrl_r.cwe) && count_r == CNT_MAX;
  endsequence

  a_cwe_guard_hold: assert property (
    s_guarded_ctrl_wr(CWE_GUARD_BIT) |=> $stable(ctrl_r.cwe))
    else $error("counter enable changed with guard set");
  a_cwe_guard_take: assert property (
    ctrl_wr && !wd[CWE_GUARD_BIT] |=> ctrl_r.cwe == $past(wd[CWE_BIT]))
    else $error("counter enable missed unguarded write");
  a_count_write_lock: assert property (
    count_wr && !ctrl_r.cwe && !tick |=> $stable(count_r))
    else $error("counter written while locked");
  a_rwe_guard_hold: assert property (
    s_guarded_ctrl_wr(RWE_GUARD_BIT) |=> $stable(ctrl_r.rwe))
    else $error("register enable changed with guard set");
  a_run_needs_rwe: assert property (
    ctrl_wr && !ctrl_r.rwe |=> $stable(ctrl_r.run))
    else $error("run changed without register enable");
  a_run_guard_hold: assert property (
    s_guarded_ctrl_wr(RUN_GUARD_BIT) |=> $stable(ctrl_r.run))
    else $error("run changed with guard set");
  a_count_hold_idle: assert property (
    !ctrl_r.run && !count_wr |=> $stable(count_r))
    else $error("counter moved while stopped");
  a_run_set_clear: assert property (
    ctrl_wr && ctrl_r.rwe && !wd[RUN_GUARD_BIT]
      |=> ctrl_r.run == $past(wd[RUN_BIT]))
    else $error("run enable did not follow write");
  a_overflow_effect: assert property (
    s_overflow_seen |=> wdt_reset && ctrl_r.flag && count_r == '0 ##1 !wdt_reset)
    else $error("overflow did not reset and flag");
  a_flag_clear: assert property (
    ctrl_wr && ctrl_r.rwe && !wd[FLAG_GUARD_BIT] && !wd[FLAG_BIT] && !overflow
      |=> !ctrl_r.flag)
    else $error("flag not cleared by write");
  a_flag_guard_hold: assert property (
    s_guarded_ctrl_wr(FLAG_GUARD_BIT) && !overflow |=> $stable(ctrl_r.flag))
    else $error("flag changed with guard set");
  a_guard_reads_one: assert property (
    ar_take && s_axi_araddr == CTRL_OFF
      |=> rvalid_r && rdata_r[CWE_GUARD_BIT] && rdata_r[RWE_GUARD_BIT]
          && rdata_r[RUN_GUARD_BIT] && rdata_r[FLAG_GUARD_BIT])
    else $error("guard bit read as zero");

endmodule
`default_nettype wire

// ===== dv/test_watchdog_guarded_control.sv
`default_nettype none
module test_watchdog_guarded_control
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, wdt_reset;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  int fail_count = 0;
  int num_checks = 0;
  ctrl_s m;

  wdt_guarded_control #(.CNT_W(4), .TICK_DIV(1)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq), .wdt_reset(wdt_reset)
  );

  // Free running 100 MHz clock
  always #5 aclk = ~aclk;

  // Expected control bits after one write
  function automatic ctrl_s nxt(ctrl_s c, logic [7:0] d);
    ctrl_s n;
    n = c;
    if (!d[7]) n.cwe = d[6];
    if (!d[5]) n.rwe = d[4];
    if (!d[3] && c.rwe) n.run = d[2];
    if (!d[1] && c.rwe) n.flag = d[0];
    return n;
  endfunction

  // Expected control readback, guards read high
  function automatic logic [31:0] img(ctrl_s c);
    return {24'h0, 1'b1, c.cwe, 1'b1, c.rwe, 1'b1, c.run, 1'b1, c.flag};
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Write address and data together, wait for the response
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rdr(logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // Control write, model update and readback
  task automatic cw(logic [7:0] d);
    wr(CTRL_OFF, {24'h0, d});
    m = nxt(m, d);
    rdr(CTRL_OFF);
    chk("ctrl", img(m), rd);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    complete_run;
  end

  // Main sequence
  initial begin
    logic [7:0] d;
    logic [31:0] v;
    int i;
    void'($urandom(53));
    do_reset;
    m = '0;
    rdr(CTRL_OFF);
    chk("ctrl_rst", img(m), rd);
    cw(8'hc0);
    wr(COUNT_OFF, 32'h5);
    rdr(COUNT_OFF);
    chk("cnt_locked", 32'h0, rd);
    cw(8'h40);
    wr(COUNT_OFF, 32'h5);
    rdr(COUNT_OFF);
    chk("cnt_open", 32'h5, rd);
    cw(8'h96);
    cw(8'ha6);
    cw(8'ha2);
    rdr(COUNT_OFF);
    v = rd;
    chk("cnt_ran", 32'h1, 32'(rd > 32'h5));
    repeat (5) @(posedge aclk);
    rdr(COUNT_OFF);
    chk("cnt_hold", v, rd);
    // Random control writes, run bit never written high
    repeat (30) begin
      d = 8'($urandom) & 8'hfb;
      cw(d);
    end
    cw(8'h5a);
    wr(COUNT_OFF, 32'h0);
    cw(8'ha6);
    v = 32'h0;
    for (i = 0; i < 40 && v == 32'h0; i++) begin
      @(posedge aclk);
      v = {31'h0, wdt_reset};
    end
    chk("ovf_pulse", 32'h1, v);
    m.flag = 1'b1;
    cw(8'ha2);
    rdr(ISTAT_OFF);
    chk("status", 32'h1, rd);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(IMASK_OFF, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(ISTAT_OFF, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq_off", 32'h0, {31'h0, irq});
    cw(8'ha8);
    cw(8'ha9);
    do_reset;
    m = '0;
    rdr(CTRL_OFF);
    chk("ctrl_rst2", img(m), rd);
    rdr(4'h2);
    chk("unmap_rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    wr(4'h6, 32'hff);
    chk("unmap_bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    complete_run;
  end
endmodule
`default_nettype wire
